// ---- hw/tw_host.sv ----
// What this block does
// - both lines high means bus idle
// - byte slot is eight data plus ack
// - data bytes go out MSB first
// - receiver may hold clock low to wait
// - START/STOP are data edges with clock high
// - first byte is address plus direction bit
// - data changes only while clock low
// - master clocks ack, transmitter releases data
// - receiver acks by holding data low
// - no address match: leave high, then STOP
// - master reader nacks last byte only
// - losing master releases data, waits idle
`timescale 1ns/1ps
`default_nettype none

module tw_host
    import tw_pkg::*;
#(
    parameter logic [15:0] QUARTER_COUNT = 16'(QUARTER_CYCLES),
    parameter logic [6:0]  OWN_ADDRESS   = 7'h2A  // arbitrary
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       bus_clock_pin_in,
    output logic            bus_clock_pin_out,
    output logic            bus_clock_pin_oe_n,
    input  wire logic       bus_data_pin_in,
    output logic            bus_data_pin_out,
    output logic            bus_data_pin_oe_n,
    input  wire logic       cmd_valid,
    output logic            cmd_ready,
    input  wire logic       cmd_start,
    input  wire logic       cmd_stop,
    input  wire logic       cmd_read,
    input  wire logic       cmd_ack,
    input  wire logic [7:0] cmd_data,
    output logic            rsp_valid,
    output logic [7:0]      rsp_data,
    output logic            rsp_nack,
    output logic            rsp_lost,
    output logic            slv_rx_valid,
    output logic [7:0]      slv_rx_data,
    output logic            slv_tx_req,
    input  wire logic [7:0] slv_tx_data
);

    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic bus_busy;
    logic line_idle;

    tw_line_monitor u_monitor (
        .clk       (clk),
        .rst       (rst),
        .scl_pin   (bus_clock_pin_in),
        .sda_pin   (bus_data_pin_in),
        .scl_s     (scl_s),
        .sda_s     (sda_s),
        .scl_rise  (scl_rise),
        .scl_fall  (scl_fall),
        .start_det (start_det),
        .stop_det  (stop_det),
        .bus_busy  (bus_busy)
    );

    assign line_idle = ~bus_busy & scl_s & sda_s;

    // master unit
    tw_mst_state_t m_state, next_m_state;
    logic [1:0]    m_phase, next_m_phase;
    logic [15:0]   m_timer, next_m_timer;
    logic [3:0]    m_cnt, next_m_cnt;
    logic [7:0]    m_shift, next_m_shift;
    logic          m_scl_low, next_m_scl_low;
    logic          m_sda_low, next_m_sda_low;
    logic          m_read, next_m_read;
    logic          m_ack, next_m_ack;
    logic          m_stop_pend, next_m_stop_pend;
    logic          next_rsp_valid;
    logic [7:0]    next_rsp_data;
    logic          next_rsp_nack;
    logic          next_rsp_lost;
    logic          tick;
    logic [15:0]   phase_len;
    logic          take;

    // one unit is QUARTER_COUNT clocks, i.e. BIT_TIME_NS / 10 rounded up to whole clk periods
    assign phase_len = m_phase[1] ? (CLOCK_HIGH_UNITS >> 1) * QUARTER_COUNT
                                  : (CLOCK_LOW_UNITS >> 1) * QUARTER_COUNT;
    // high phase only runs once the clock is really seen high
    assign tick = (m_timer == phase_len - 16'h1)
                  && (m_phase != PHASE_HIGH || scl_s);
    assign cmd_ready = (m_state == TW_M_IDLE) ? line_idle : (m_state == TW_M_HOLD);
    assign take = cmd_valid & cmd_ready;

    always_comb begin
        next_m_state     = m_state;
        next_m_phase     = m_phase;
        next_m_timer     = m_timer;
        next_m_cnt       = m_cnt;
        next_m_shift     = m_shift;
        next_m_scl_low   = m_scl_low;
        next_m_sda_low   = m_sda_low;
        next_m_read      = m_read;
        next_m_ack       = m_ack;
        next_m_stop_pend = m_stop_pend;
        next_rsp_valid   = 1'h0;
        next_rsp_data    = rsp_data;
        next_rsp_nack    = rsp_nack;
        next_rsp_lost    = rsp_lost;
        if (m_state != TW_M_IDLE && m_state != TW_M_HOLD) begin
            next_m_timer = tick ? 16'h0 : m_timer + 16'h1;
            if (m_phase == PHASE_HIGH && !scl_s) begin
                next_m_timer = 16'h0;
            end
            if (tick) begin
                next_m_phase = m_phase + 2'h1;
            end
        end
        case (m_state)
            TW_M_IDLE, TW_M_HOLD: begin
                next_m_timer = 16'h0;
                next_m_phase = RESET_PHASE;
                if (take) begin
                    next_m_shift     = cmd_read ? IDLE_BYTE : cmd_data;
                    next_m_read      = cmd_read;
                    next_m_ack       = cmd_ack;
                    next_m_stop_pend = cmd_stop;
                    next_m_cnt       = RESET_COUNT;
                    // from idle every command opens with a START
                    if (cmd_start || m_state == TW_M_IDLE) begin
                        next_m_state = TW_M_START;
                    end else begin
                        next_m_state = TW_M_BIT;
                    end
                end
            end
            TW_M_START: begin
                if (tick) begin
                    case (m_phase)
                        2'h0: next_m_sda_low = 1'h0;
                        2'h1: next_m_scl_low = 1'h0;
                        2'h2: next_m_sda_low = 1'h0;
                        default: begin
                            if (!sda_s) begin
                                // someone else already started
                                next_m_state   = TW_M_IDLE;
                                next_rsp_valid = 1'h1;
                                next_rsp_lost  = 1'h1;
                                next_rsp_nack  = 1'h1;
                            end else begin
                                next_m_sda_low = 1'h1;
                                next_m_state   = TW_M_SETUP;
                            end
                        end
                    endcase
                end
            end
            TW_M_SETUP: begin
                if (tick) begin
                    next_m_scl_low = 1'h1;
                    next_m_phase   = RESET_PHASE;
                    next_m_state   = TW_M_BIT;
                end
            end
            TW_M_BIT: begin
                if (tick) begin
                    case (m_phase)
                        2'h0: begin
                            // data set up in the low phase only
                            if (m_cnt <= LAST_DATA_BIT) begin
                                next_m_sda_low = ~m_read & ~m_shift[7];
                            end else begin
                                next_m_sda_low = m_read & m_ack;
                            end
                        end
                        2'h1: next_m_scl_low = 1'h0;
                        2'h2: next_m_scl_low = 1'h0;
                        default: begin
                            next_m_scl_low = 1'h1;
                            next_m_cnt     = m_cnt + 4'h1;
                            if (m_cnt <= LAST_DATA_BIT) begin
                                next_m_shift = {m_shift[6:0], sda_s};
                            end
                            if (m_cnt <= LAST_DATA_BIT && !m_read && m_shift[7] && !sda_s) begin
                                next_m_scl_low = 1'h0;
                                next_m_sda_low = 1'h0;
                                next_m_state   = TW_M_IDLE;
                                next_rsp_valid = 1'h1;
                                next_rsp_lost  = 1'h1;
                                next_rsp_nack  = 1'h1;
                                next_rsp_data  = m_shift;
                            end else if (m_cnt == ACK_SLOT) begin
                                next_m_sda_low = 1'h0;
                                next_rsp_valid = 1'h1;
                                next_rsp_lost  = 1'h0;
                                next_rsp_nack  = m_read ? ~m_ack : sda_s;
                                next_rsp_data  = m_shift;
                                next_m_phase   = RESET_PHASE;
                                if ((!m_read && sda_s) || m_stop_pend) begin
                                    next_m_state = TW_M_STOP;
                                end else begin
                                    next_m_state = TW_M_HOLD;
                                end
                            end
                        end
                    endcase
                end
            end
            TW_M_STOP: begin
                if (tick) begin
                    case (m_phase)
                        2'h0: next_m_sda_low = 1'h1;
                        2'h1: next_m_scl_low = 1'h0;
                        2'h2: next_m_scl_low = 1'h0;
                        default: begin
                            next_m_sda_low = 1'h0;
                            next_m_state   = TW_M_IDLE;
                        end
                    endcase
                end
            end
            default: begin
                next_m_state   = TW_M_IDLE;
                next_m_scl_low = 1'h0;
                next_m_sda_low = 1'h0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            m_state     <= TW_M_IDLE;
            m_phase     <= RESET_PHASE;
            m_timer     <= 16'h0;
            m_cnt       <= RESET_COUNT;
            m_shift     <= RESET_BYTE;
            m_scl_low   <= 1'h0;
            m_sda_low   <= 1'h0;
            m_read      <= 1'h0;
            m_ack       <= 1'h0;
            m_stop_pend <= 1'h0;
            rsp_valid   <= 1'h0;
            rsp_data    <= RESET_BYTE;
            rsp_nack    <= 1'h0;
            rsp_lost    <= 1'h0;
        end else begin
            m_state     <= next_m_state;
            m_phase     <= next_m_phase;
            m_timer     <= next_m_timer;
            m_cnt       <= next_m_cnt;
            m_shift     <= next_m_shift;
            m_scl_low   <= next_m_scl_low;
            m_sda_low   <= next_m_sda_low;
            m_read      <= next_m_read;
            m_ack       <= next_m_ack;
            m_stop_pend <= next_m_stop_pend;
            rsp_valid   <= next_rsp_valid;
            rsp_data    <= next_rsp_data;
            rsp_nack    <= next_rsp_nack;
            rsp_lost    <= next_rsp_lost;
        end
    end

    // slave unit, paced only by the clock edges it observes
    tw_slv_state_t s_state, next_s_state;
    logic [3:0]    s_cnt, next_s_cnt;
    logic [7:0]    s_shift, next_s_shift;
    logic          s_sda_low, next_s_sda_low;
    logic          s_read, next_s_read;
    logic          next_slv_rx_valid;
    logic [7:0]    next_slv_rx_data;
    logic          next_slv_tx_req;

    always_comb begin
        next_s_state      = s_state;
        next_s_cnt        = s_cnt;
        next_s_shift      = s_shift;
        next_s_sda_low    = s_sda_low;
        next_s_read       = s_read;
        next_slv_rx_valid = 1'h0;
        next_slv_rx_data  = slv_rx_data;
        next_slv_tx_req   = 1'h0;
        if (start_det) begin
            next_s_state   = TW_S_ADDR;
            next_s_cnt     = RESET_COUNT;
            next_s_sda_low = 1'h0;
        end else if (stop_det) begin
            next_s_state   = TW_S_IDLE;
            next_s_sda_low = 1'h0;
        end else begin
            case (s_state)
                TW_S_IDLE: next_s_sda_low = 1'h0;
                TW_S_ADDR, TW_S_RX: begin
                    if (scl_rise && s_cnt < ACK_SLOT) begin
                        next_s_shift = {s_shift[6:0], sda_s};
                        next_s_cnt   = s_cnt + 4'h1;
                    end else if (scl_fall && s_cnt == ACK_SLOT) begin
                        if (s_state == TW_S_RX) begin
                            next_s_state      = TW_S_ACK;
                            next_s_sda_low    = 1'h1;
                            next_slv_rx_valid = 1'h1;
                            next_slv_rx_data  = s_shift;
                        end else if (s_shift[7:1] == OWN_ADDRESS) begin
                            next_s_state   = TW_S_ACK;
                            next_s_sda_low = 1'h1;
                            next_s_read    = s_shift[0];
                        end else begin
                            next_s_state = TW_S_IDLE;
                        end
                    end
                end
                TW_S_ACK: begin
                    if (scl_fall) begin
                        next_s_cnt = RESET_COUNT;
                        if (s_read) begin
                            next_slv_tx_req = 1'h1;
                            next_s_shift    = slv_tx_data;
                            next_s_sda_low  = ~slv_tx_data[7];
                            next_s_state    = TW_S_TX;
                        end else begin
                            next_s_sda_low = 1'h0;
                            next_s_state   = TW_S_RX;
                        end
                    end
                end
                TW_S_TX: begin
                    if (scl_rise) begin
                        next_s_cnt = s_cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (s_cnt == ACK_SLOT) begin
                            next_s_sda_low = 1'h0;
                            next_s_state   = TW_S_TACK;
                        end else begin
                            next_s_sda_low = ~s_shift[6];
                            next_s_shift   = {s_shift[6:0], 1'h0};
                        end
                    end
                end
                TW_S_TACK: begin
                    if (scl_rise) begin
                        // a nack ends sending; the line stays released
                        next_s_state = sda_s ? TW_S_IDLE : TW_S_ACK;
                    end
                end
                default: begin
                    next_s_state   = TW_S_IDLE;
                    next_s_sda_low = 1'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_state      <= TW_S_IDLE;
            s_cnt        <= RESET_COUNT;
            s_shift      <= RESET_BYTE;
            s_sda_low    <= 1'h0;
            s_read       <= 1'h0;
            slv_rx_valid <= 1'h0;
            slv_rx_data  <= RESET_BYTE;
            slv_tx_req   <= 1'h0;
        end else begin
            s_state      <= next_s_state;
            s_cnt        <= next_s_cnt;
            s_shift      <= next_s_shift;
            s_sda_low    <= next_s_sda_low;
            s_read       <= next_s_read;
            slv_rx_valid <= next_slv_rx_valid;
            slv_rx_data  <= next_slv_rx_data;
            slv_tx_req   <= next_slv_tx_req;
        end
    end

    // open drain: only ever pull low, never drive high
    assign bus_clock_pin_out  = 1'h0;
    assign bus_data_pin_out   = 1'h0;
    assign bus_clock_pin_oe_n = ~m_scl_low;
    // both units share one pair of lines, so each hears the other
    assign bus_data_pin_oe_n  = ~(m_sda_low | s_sda_low);

endmodule : tw_host

`default_nettype wire

// ---- hw/tw_line_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none

module tw_line_monitor
    import tw_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic scl_pin,
    input  wire logic sda_pin,
    output logic      scl_s,
    output logic      sda_s,
    output logic      scl_rise,
    output logic      scl_fall,
    output logic      start_det,
    output logic      stop_det,
    output logic      bus_busy
);

    logic [1:0] scl_meta;
    logic [1:0] sda_meta;
    logic       scl_prev;
    logic       sda_prev;
    logic       next_busy;

    // first stage only feeds the second stage
    assign scl_s     = scl_meta[1];
    assign sda_s     = sda_meta[1];
    assign scl_rise  = scl_s & ~scl_prev;
    assign scl_fall  = ~scl_s & scl_prev;
    assign start_det = scl_s & scl_prev & sda_prev & ~sda_s;
    assign stop_det  = scl_s & scl_prev & ~sda_prev & sda_s;

    always_comb begin
        next_busy = bus_busy;
        if (start_det) begin
            next_busy = 1'h1;
        end else if (stop_det) begin
            next_busy = 1'h0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_meta <= 2'h3;
            sda_meta <= 2'h3;
            scl_prev <= 1'h1;
            sda_prev <= 1'h1;
            bus_busy <= 1'h0;
        end else begin
            scl_meta <= {scl_meta[0], scl_pin};
            sda_meta <= {sda_meta[0], sda_pin};
            scl_prev <= scl_s;
            sda_prev <= sda_s;
            bus_busy <= next_busy;
        end
    end

endmodule : tw_line_monitor

`default_nettype wire

// ---- hw/tw_pkg.sv ----
package tw_pkg;

    localparam int CLK_PERIOD_NS  = 20;
    // standard rate: 10 us clock period made of ten timing units
    localparam int BIT_TIME_NS    = 10000;
    localparam int QUARTER_CYCLES = (BIT_TIME_NS + 10 * CLK_PERIOD_NS - 1) / (10 * CLK_PERIOD_NS);

    localparam logic [15:0] CLOCK_LOW_UNITS  = 16'h0006;
    localparam logic [15:0] CLOCK_HIGH_UNITS = 16'h0004;

    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_SLOT      = 4'h8;
    localparam logic [1:0] PHASE_HIGH    = 2'h2;
    localparam logic [1:0] PHASE_SAMPLE  = 2'h3;

    localparam logic [7:0] RESET_BYTE  = 8'h00;
    localparam logic [7:0] IDLE_BYTE   = 8'hFF;
    localparam logic [3:0] RESET_COUNT = 4'h0;
    localparam logic [1:0] RESET_PHASE = 2'h0;

    typedef enum logic [2:0] {
        TW_M_IDLE,
        TW_M_HOLD,
        TW_M_START,
        TW_M_SETUP,
        TW_M_BIT,
        TW_M_STOP
    } tw_mst_state_t;

    typedef enum logic [2:0] {
        TW_S_IDLE,
        TW_S_ADDR,
        TW_S_ACK,
        TW_S_RX,
        TW_S_TX,
        TW_S_TACK
    } tw_slv_state_t;

endpackage : tw_pkg

// ---- test/tw_host_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module tw_host_checker #(
    parameter logic [15:0] QUARTER_COUNT = 16'h0004
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic bus_clock_pin_in,
    input wire logic bus_clock_pin_oe_n,
    input wire logic bus_clock_pin_out,
    input wire logic bus_data_pin_out,
    input wire logic bus_data_pin_in,
    input wire logic bus_data_pin_oe_n,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic rsp_nack,
    input wire logic rsp_lost,
    input wire logic slv_rx_valid,
    input wire logic slv_tx_req
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic [15:0] low_cnt;
    logic [15:0] next_low_cnt;
    always_comb begin
        next_low_cnt = bus_clock_pin_oe_n ? 16'h0000 : low_cnt + 16'h0001;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            low_cnt <= 16'h0000;
        else
            low_cnt <= next_low_cnt;
    end
    // a master left in hold keeps ready high, so only finished transfers qualify
    sequence s_done_no_hold;
        rsp_valid ##1 (rsp_nack && !rsp_lost && !cmd_ready);
    endsequence
    sequence s_stop_seen;
        ##[1:80] (bus_clock_pin_in && $rose(bus_data_pin_oe_n));
    endsequence
    chk_rsp_one_cycle: assert property (rsp_valid |=> !rsp_valid)
        else $error("rsp_valid held over one cycle");
    chk_ready_bus_idle: assert property (cmd_ready |-> !bus_clock_pin_oe_n
        || (bus_clock_pin_in && bus_data_pin_in)) else $error("ready on busy lines");
    chk_accept_busy: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
        else $error("ready after accept");
    chk_nack_stop: assert property (s_done_no_hold |-> s_stop_seen)
        else $error("no stop after nack");
    chk_low_phase: assert property ($rose(bus_clock_pin_oe_n)
        |-> low_cnt >= 6 * QUARTER_COUNT) else $error("clock low phase short");
    chk_lost_release: assert property (rsp_valid && rsp_lost
        |-> bus_data_pin_oe_n && bus_clock_pin_oe_n) else $error("lines held after loss");
    chk_rx_pulse: assert property (slv_rx_valid |=> !slv_rx_valid)
        else $error("slv_rx_valid too long");
    chk_txreq_pulse: assert property (slv_tx_req |=> !slv_tx_req)
        else $error("slv_tx_req too long");
    chk_pins_low_only: assert property (!bus_clock_pin_out && !bus_data_pin_out)
        else $error("pin driven high");
endmodule : tw_host_checker
bind tw_host tw_host_checker #(.QUARTER_COUNT(QUARTER_COUNT)) u_chk (
    .clk(clk), .rst(rst), .bus_clock_pin_in(bus_clock_pin_in),
    .bus_clock_pin_oe_n(bus_clock_pin_oe_n), .bus_data_pin_in(bus_data_pin_in),
    .bus_clock_pin_out(bus_clock_pin_out), .bus_data_pin_out(bus_data_pin_out),
    .bus_data_pin_oe_n(bus_data_pin_oe_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_nack(rsp_nack), .rsp_lost(rsp_lost),
    .slv_rx_valid(slv_rx_valid), .slv_tx_req(slv_tx_req));
`default_nettype wire

// ---- test/tw_host_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module tw_host_test;
    import tw_pkg::*;
    logic       clk, rst, cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_ack, fight, stretch;
    logic       scl_oe_n, sda_oe_n, m_scl, m_sda, cmd_ready, rsp_valid, rsp_nack, rsp_lost;
    logic       slv_rx_valid, slv_tx_req;
    logic [7:0] cmd_data, slv_tx_data, rsp_data, slv_rx_data, rx_last;
    logic [7:0] got_rx = 8'h00;
    int         n_errors = 0;
    int         compares = 0;
    int         n_req = 0;
    wire logic  scl_w = scl_oe_n & m_scl;
    wire logic  sda_w = sda_oe_n & m_sda;
    tw_host #(.QUARTER_COUNT(16'h0004)) u_dut (
        .clk(clk), .rst(rst), .bus_clock_pin_in(scl_w), .bus_clock_pin_out(),
        .bus_clock_pin_oe_n(scl_oe_n), .bus_data_pin_in(sda_w), .bus_data_pin_out(),
        .bus_data_pin_oe_n(sda_oe_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_read(cmd_read), .cmd_ack(cmd_ack),
        .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack),
        .rsp_lost(rsp_lost), .slv_rx_valid(slv_rx_valid), .slv_rx_data(slv_rx_data),
        .slv_tx_req(slv_tx_req), .slv_tx_data(slv_tx_data));
    tw_slave_model u_slave (.scl(scl_w), .sda(sda_w), .fight(fight), .stretch(stretch),
        .scl_rel(m_scl), .sda_rel(m_sda), .rx_last(rx_last));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        if (slv_rx_valid)
            got_rx <= slv_rx_data;
        if (slv_tx_req)
            n_req <= n_req + 1;
    end
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s: expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic cmd(input logic st, sp, rd, ak, input logic [7:0] d, ex, input logic nk, lt);
        int i;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_start <= st;
        cmd_stop <= sp;
        cmd_read <= rd;
        cmd_ack <= ak;
        cmd_data <= d;
        i = 0;
        do begin
            @(negedge clk);
            i++;
        end while (cmd_ready !== 1'b1 && i < 4000);
        @(posedge clk);
        cmd_valid <= 1'b0;
        while (rsp_valid !== 1'b1 && i < 8000) begin
            @(negedge clk);
            i++;
        end
        check("rsp_valid", 8'h01, {7'h00, rsp_valid});
        if (!lt)
            check("rsp_data", ex, rsp_data);
        check("rsp_nack", {7'h00, nk}, {7'h00, rsp_nack});
        check("rsp_lost", {7'h00, lt}, {7'h00, rsp_lost});
    endtask : cmd
    task automatic wait_idle();
        int i;
        i = 0;
        while (cmd_ready !== 1'b1 && i < 400) begin
            @(negedge clk);
            i++;
        end
        check("bus free", 8'h01, {7'h00, cmd_ready});
    endtask : wait_idle
    task automatic t_write(input logic sl, input logic [7:0] d);
        stretch = sl;
        cmd(1'b1, 1'b0, 1'b0, 1'b0, 8'hA0, 8'hA0, 1'b0, 1'b0);
        cmd(1'b0, 1'b1, 1'b0, 1'b0, d, d, 1'b0, 1'b0);
        check("model rx", d, rx_last);
        wait_idle();
        stretch = 1'b0;
    endtask : t_write
    task automatic t_read();
        cmd(1'b1, 1'b0, 1'b0, 1'b0, 8'hA0, 8'hA0, 1'b0, 1'b0);
        cmd(1'b0, 1'b0, 1'b0, 1'b0, 8'h0F, 8'h0F, 1'b0, 1'b0);
        cmd(1'b1, 1'b0, 1'b0, 1'b0, 8'hA1, 8'hA1, 1'b0, 1'b0);
        cmd(1'b0, 1'b0, 1'b1, 1'b1, IDLE_BYTE, 8'hC3, 1'b0, 1'b0);
        cmd(1'b0, 1'b1, 1'b1, 1'b0, IDLE_BYTE, 8'h87, 1'b1, 1'b0);
        wait_idle();
    endtask : t_read
    task automatic t_nack();
        // no stop requested: the nack alone must close the transfer
        cmd(1'b1, 1'b0, 1'b0, 1'b0, 8'h66, 8'h66, 1'b1, 1'b0);
        wait_idle();
    endtask : t_nack
    task automatic t_self();
        cmd(1'b1, 1'b0, 1'b0, 1'b0, 8'h54, 8'h54, 1'b0, 1'b0);
        cmd(1'b0, 1'b1, 1'b0, 1'b0, 8'h3C, 8'h3C, 1'b0, 1'b0);
        check("slave rx", 8'h3C, got_rx);
        cmd(1'b1, 1'b0, 1'b0, 1'b0, 8'h55, 8'h55, 1'b0, 1'b0);
        cmd(1'b0, 1'b1, 1'b1, 1'b0, IDLE_BYTE, 8'h96, 1'b1, 1'b0);
        check("tx requests", 8'h01, n_req[7:0]);
    endtask : t_self
    task automatic t_lost();
        wait_idle();
        fork
            cmd(1'b1, 1'b0, 1'b0, 1'b0, 8'hA0, 8'hA0, 1'b1, 1'b1);
            begin
                wait (scl_oe_n === 1'b0);
                @(negedge clk);
                fight = 1'b1;
            end
        join
        repeat (20) @(negedge clk);
        check("ready while busy", 8'h00, {7'h00, cmd_ready});
        fight = 1'b0;
        wait_idle();
    endtask : t_lost
    task automatic wrap_up();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        rst = 1'b1;
        {cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_ack, fight, stretch} = 7'h00;
        cmd_data = 8'h00;
        slv_tx_data = 8'h96;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_write(1'b0, 8'h5A);
        t_write(1'b1, 8'hE7);
        t_read();
        t_nack();
        t_self();
        t_lost();
        wrap_up();
    end
    initial begin
        #400000;
        n_errors++;
        wrap_up();
    end
endmodule : tw_host_test
`default_nettype wire

// ---- test/tw_slave_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tw_slave_model #(
    parameter logic [6:0] ADDR = 7'h50,
    parameter logic [7:0] TX0  = 8'hC3
) (
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       fight,
    input  wire logic       stretch,
    output logic            scl_rel,
    output logic            sda_rel,
    output logic [7:0]      rx_last
);
    logic [7:0] sh = 8'h00;
    logic [7:0] tx = 8'h00;
    logic       ps = 1'b1;
    logic       pd = 1'b1;
    logic       act = 1'b0;
    logic       adr = 1'b0;
    logic       rd = 1'b0;
    logic       drv = 1'b1;
    int         cnt = 0;
    initial scl_rel = 1'b1;
    initial rx_last = 8'h00;
    // fight stands in for a rival master sending low
    assign sda_rel = drv & ~fight;
    always @(scl or sda) begin
        if (scl && ps && pd && !sda) begin
            act = 1'b1;
            adr = 1'b1;
            cnt = 0;
        end else if (scl && ps && !pd && sda) begin
            act = 1'b0;
            drv = 1'b1;
        end else if (scl && !ps && act) begin
            if (cnt < 8)
                sh = {sh[6:0], sda};
            else if (rd && sda)
                act = 1'b0;
            cnt = cnt + 1;
        end else if (!scl && ps && act) begin
            drv = 1'b1;
            if (cnt == 8 && adr) begin
                adr = 1'b0;
                act = (sh[7:1] == ADDR);
                rd = sh[0];
                tx = TX0;
                drv = ~act;
            end else if (cnt == 8 && !rd) begin
                rx_last = sh;
                drv = 1'b0;
            end else if (cnt == 8)
                tx = {tx[6:0], tx[7]};
            if (cnt == 9)
                cnt = 0;
            if (rd && !adr && cnt < 8)
                drv = tx[7 - cnt];
        end
        ps = scl;
        pd = sda;
    end
    always @(negedge scl) begin
        if (stretch && act) begin
            scl_rel = 1'b0;
            // outlast the master's own low phase so it has to wait
            #1000;
            scl_rel = 1'b1;
        end
    end
endmodule : tw_slave_model
`default_nettype wire
